// *** timer16_pkg.sv ***
package timer16_pkg;
    // register index map of the byte-wide i/o port
    localparam logic [3:0] ADDR_FORCE = 4'h0;
    localparam logic [3:0] ADDR_CNT_LO = 4'h1;
    localparam logic [3:0] ADDR_CNT_HI = 4'h2;
    localparam logic [3:0] ADDR_CMPA_LO = 4'h3;
    localparam logic [3:0] ADDR_CMPA_HI = 4'h4;
    localparam logic [3:0] ADDR_CMPB_LO = 4'h5;
    localparam logic [3:0] ADDR_CMPB_HI = 4'h6;
    localparam logic [3:0] ADDR_CAP_LO = 4'h7;
    localparam logic [3:0] ADDR_CAP_HI = 4'h8;
    localparam logic [3:0] ADDR_MASK = 4'h9;
    localparam logic [3:0] ADDR_FLAGS = 4'ha;

    // bit positions in force, mask and flag registers
    localparam int BIT_FORCE_A = 7;
    localparam int BIT_FORCE_B = 6;
    localparam int BIT_CAPTURE = 5;
    localparam int BIT_MATCH_B = 2;
    localparam int BIT_MATCH_A = 1;
    localparam int BIT_OVERFLOW = 0;
    // implemented bits of mask and flags; the rest read zero
    localparam logic [7:0] IRQ_BITS_USED = 8'h27;

    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] RESET_FLAGS = 8'h00;

    // counter extremes and fixed tops
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;

    // how the waveform mode makes the counter move
    typedef enum logic [1:0] {
        SEQ_NORMAL,
        SEQ_CLEAR_ON_MATCH,
        SEQ_FAST,
        SEQ_PHASE
    } count_seq_t;
endpackage : timer16_pkg

// *** timer16_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// - force strobes for a at bit 7, b at bit 6, only in non-pwm modes
// - writing one to a force bit applies an immediate match to that channel
// - force bits are strobes; effect depends on compare mode at write time
// - a forced match raises no interrupt and never clears the counter
// - force bits always read as zero
// - counter reached as two bytes through a shared high-byte latch
// - a cpu write to the counter blocks matches on the next timer tick
// - compare registers are compared with the counter continuously
// - compare register writes update both bytes together via the latch
// - capture register loads the counter on a capture event while it is not serving as top; a cpu write in that cycle wins
// - capture register reads return both bytes consistently via the latch
// - capture register serves as top in the modes that assign it
// - mask holds capture bit 5, b bit 2, a bit 1, overflow bit 0
// - bits 7, 6, 4, 3 of mask and flags are unused and read zero
// - capture flag sets on capture, or at top when capture is top
// - match flag sets on the timer tick after counter equals compare
// - a force strobe never sets a match flag
// - flags clear on vector execution or on writing one to them
// - overflow flag sets on overflow in normal and clear-on-match modes
// - overflow at max, at bottom in phase modes, at top in fast modes
module timer16_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // i/o register port
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // timer clock enable and mode from the control registers
    input wire logic timer_tick,
    input wire logic [3:0] waveform_mode_select,
    // capture event, already edge-selected and filtered
    input wire logic capture_event,
    // interrupt controller
    input wire logic global_irq_enable,
    input wire logic ack_capture,
    input wire logic ack_match_a,
    input wire logic ack_match_b,
    input wire logic ack_overflow,
    output logic irq_capture,
    output logic irq_match_a,
    output logic irq_match_b,
    output logic irq_overflow,
    // waveform generator events
    output logic match_a,
    output logic match_b,
    output logic force_match_a,
    output logic force_match_b
);
    import timer16_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // mode decoding
    function automatic count_seq_t seq_of(input logic [3:0] mode);
        case (mode)
            4'h0: seq_of = SEQ_NORMAL;
            4'h4, 4'hc: seq_of = SEQ_CLEAR_ON_MATCH;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: seq_of = SEQ_FAST;
            4'hd: seq_of = SEQ_NORMAL; // reserved, treated as normal
            default: seq_of = SEQ_PHASE;
        endcase
    endfunction : seq_of

    function automatic logic [15:0] top_of(input logic [3:0] mode,
                                           input logic [15:0] cmp_a,
                                           input logic [15:0] cap);
        case (mode)
            4'h1, 4'h5: top_of = TOP_8BIT;
            4'h2, 4'h6: top_of = TOP_9BIT;
            4'h3, 4'h7: top_of = TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: top_of = cmp_a;
            4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
            default: top_of = COUNT_MAX;
        endcase
    endfunction : top_of

    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [7:0] temp_hi;
    logic [7:0] mask;
    logic [7:0] flags;
    logic count_down;
    logic block_match;

    count_seq_t seq;
    wire logic [15:0] top_value = top_of(waveform_mode_select, cmp_a, cap);
    wire logic capture_is_top = (waveform_mode_select == 4'h8)
        || (waveform_mode_select == 4'ha) || (waveform_mode_select == 4'hc)
        || (waveform_mode_select == 4'he);
    wire logic non_pwm = (seq == SEQ_NORMAL) || (seq == SEQ_CLEAR_ON_MATCH);
    assign seq = seq_of(waveform_mode_select);

    ////////////////////////////////////////////////////////////////////////
    // bus strobes
    wire logic wr_force = io_wr && (io_addr == ADDR_FORCE);
    wire logic wr_hi = io_wr && ((io_addr == ADDR_CNT_HI) || (io_addr == ADDR_CMPA_HI)
        || (io_addr == ADDR_CMPB_HI) || (io_addr == ADDR_CAP_HI));
    wire logic wr_cnt = io_wr && (io_addr == ADDR_CNT_LO);
    wire logic wr_cmpa = io_wr && (io_addr == ADDR_CMPA_LO);
    wire logic wr_cmpb = io_wr && (io_addr == ADDR_CMPB_LO);
    wire logic wr_cap = io_wr && (io_addr == ADDR_CAP_LO);
    wire logic wr_mask = io_wr && (io_addr == ADDR_MASK);
    wire logic wr_flags = io_wr && (io_addr == ADDR_FLAGS);
    wire logic [15:0] wr_word = {temp_hi, io_wdata};

    ////////////////////////////////////////////////////////////////////////
    // counter sequence
    logic [15:0] next_count;
    logic next_down;
    always_comb begin
        next_count = count;
        next_down = count_down;
        case (seq)
            SEQ_NORMAL: begin
                next_count = count + 16'h0001;
                next_down = 1'b0;
            end
            SEQ_CLEAR_ON_MATCH, SEQ_FAST: begin
                next_count = (count == top_value) ? COUNT_BOTTOM : count + 16'h0001;
                next_down = 1'b0;
            end
            SEQ_PHASE: begin
                if (!count_down && count >= top_value) begin
                    next_down = 1'b1;
                    next_count = (count == COUNT_BOTTOM) ? count : count - 16'h0001;
                end else if (count_down && count == COUNT_BOTTOM) begin
                    next_down = 1'b0;
                    next_count = count + 16'h0001;
                end else begin
                    next_count = count_down ? count - 16'h0001 : count + 16'h0001;
                end
            end
            default: begin
                next_count = count;
                next_down = 1'b0;
            end
        endcase
    end

    // cpu write beats the count; it also arms the one-tick match block
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= RESET_WORD;
            count_down <= 1'b0;
            block_match <= 1'b0;
        end else if (wr_cnt) begin
            count <= wr_word;
            block_match <= 1'b1;
        end else if (timer_tick) begin
            count <= next_count;
            count_down <= next_down;
            block_match <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event detection, evaluated on the timer tick except the capture pin event
    wire logic eq_a = (count == cmp_a);
    wire logic eq_b = (count == cmp_b);
    wire logic ev_match_a = timer_tick && eq_a && !block_match && !wr_cnt;
    wire logic ev_match_b = timer_tick && eq_b && !block_match && !wr_cnt;
    wire logic ev_overflow_raw = (seq == SEQ_PHASE) ? (count_down && count == COUNT_BOTTOM)
        : (seq == SEQ_FAST) ? (count == top_value) : (count == COUNT_MAX);
    wire logic ev_overflow = timer_tick && !wr_cnt && ev_overflow_raw;
    wire logic ev_capture_pin = capture_event && !capture_is_top;
    wire logic ev_capture_top = timer_tick && !wr_cnt && capture_is_top
        && (count == top_value);
    wire logic ev_capture = ev_capture_pin || ev_capture_top;

    ////////////////////////////////////////////////////////////////////////
    // compare, capture and shared high-byte latch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmp_a <= RESET_WORD;
            cmp_b <= RESET_WORD;
            cap <= RESET_WORD;
            temp_hi <= RESET_BYTE;
        end else begin
            if (wr_cmpa) begin
                cmp_a <= wr_word;
            end
            if (wr_cmpb) begin
                cmp_b <= wr_word;
            end
            if (wr_cap) begin
                cap <= wr_word;
            end else if (ev_capture_pin) begin
                cap <= count;
            end
            if (wr_hi) begin
                temp_hi <= io_wdata;
            end else if (io_rd && io_addr == ADDR_CNT_LO) begin
                temp_hi <= count[15:8];
            end else if (io_rd && io_addr == ADDR_CAP_LO) begin
                temp_hi <= cap[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mask and flags; a set in the same cycle as a clear wins
    wire logic [7:0] set_bits = {2'b00, ev_capture, 2'b00, ev_match_b, ev_match_a,
        ev_overflow};
    wire logic [7:0] ack_bits = {2'b00, ack_capture, 2'b00, ack_match_b, ack_match_a,
        ack_overflow};
    wire logic [7:0] clr_bits = (wr_flags ? io_wdata : RESET_BYTE) | ack_bits;
    wire logic [7:0] next_flags = ((flags & ~clr_bits) | set_bits) & IRQ_BITS_USED;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mask <= RESET_BYTE;
            flags <= RESET_FLAGS;
        end else begin
            if (wr_mask) begin
                mask <= io_wdata & IRQ_BITS_USED;
            end
            flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt requests: enable, global enable and flag all set
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_capture <= 1'b0;
            irq_match_a <= 1'b0;
            irq_match_b <= 1'b0;
            irq_overflow <= 1'b0;
        end else begin
            irq_capture <= global_irq_enable && mask[BIT_CAPTURE] && flags[BIT_CAPTURE];
            irq_match_a <= global_irq_enable && mask[BIT_MATCH_A] && flags[BIT_MATCH_A];
            irq_match_b <= global_irq_enable && mask[BIT_MATCH_B] && flags[BIT_MATCH_B];
            irq_overflow <= global_irq_enable && mask[BIT_OVERFLOW]
                && flags[BIT_OVERFLOW];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // match and force strobes to the waveform generator; a force is not
    // stored, so the generator applies its compare mode of that moment
    wire logic next_force_a = wr_force && io_wdata[BIT_FORCE_A] && non_pwm;
    wire logic next_force_b = wr_force && io_wdata[BIT_FORCE_B] && non_pwm;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            match_a <= 1'b0;
            match_b <= 1'b0;
            force_match_a <= 1'b0;
            force_match_b <= 1'b0;
        end else begin
            match_a <= ev_match_a;
            match_b <= ev_match_b;
            force_match_a <= next_force_a;
            force_match_b <= next_force_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the read strobe; counter and capture high bytes come from latch
    logic [7:0] rd_mux;
    always_comb begin
        case (io_addr)
            ADDR_FORCE: rd_mux = RESET_BYTE;
            ADDR_CNT_LO: rd_mux = count[7:0];
            ADDR_CMPA_LO: rd_mux = cmp_a[7:0];
            ADDR_CMPA_HI: rd_mux = cmp_a[15:8]; // compares are cpu-owned, read direct
            ADDR_CMPB_LO: rd_mux = cmp_b[7:0];
            ADDR_CMPB_HI: rd_mux = cmp_b[15:8];
            ADDR_CAP_LO: rd_mux = cap[7:0];
            ADDR_CNT_HI, ADDR_CAP_HI: rd_mux = temp_hi;
            ADDR_MASK: rd_mux = mask & IRQ_BITS_USED;
            ADDR_FLAGS: rd_mux = flags & IRQ_BITS_USED;
            default: rd_mux = RESET_BYTE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            io_rdata <= RESET_BYTE;
        end else if (io_rd) begin
            io_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_cnt_write;
        wr_cnt ##1 (timer_tick && !wr_cnt);
    endsequence

    AST_FORCE_PWM_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_force && !non_pwm) |=> !force_match_a && !force_match_b)
        else $error("force strobe left a pwm mode");
    AST_FORCE_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_force && io_wdata[BIT_FORCE_A] && non_pwm) |=> force_match_a
        ##1 (!force_match_a || $past(next_force_a)))
        else $error("force strobe a not a single pulse");
    AST_FORCE_NO_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_force && !timer_tick && !flags[BIT_MATCH_A] && !ack_match_a)
        |=> !flags[BIT_MATCH_A] || $past(ev_match_a))
        else $error("force set a match flag");
    AST_FORCE_READ_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        (io_rd && io_addr == ADDR_FORCE) |=> io_rdata == RESET_BYTE)
        else $error("force register read non-zero");
    AST_WRITE_BLOCKS: assert property (@(posedge clock) disable iff (!rst_n)
        s_cnt_write |=> !match_a && !match_b)
        else $error("match not blocked after counter write");
    AST_MATCH_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
        (timer_tick && eq_a && !block_match && !wr_cnt) |=> flags[BIT_MATCH_A] && match_a)
        else $error("match a flag not set after equality");
    AST_WORD_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        (io_wr && io_addr == ADDR_CMPB_HI) ##1 wr_cmpb |=> cmp_b[15:8] == $past(temp_hi))
        else $error("compare b high byte not from latch");
    AST_CAPTURE_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
        (ev_capture_pin && !wr_cap) |=> cap == $past(count) && flags[BIT_CAPTURE])
        else $error("capture did not load counter");
    AST_READ_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
        (io_rd && io_addr == ADDR_CAP_LO && !wr_hi) ##1 (io_rd && io_addr == ADDR_CAP_HI
        && !wr_hi) |=> io_rdata == $past(cap[15:8], 2))
        else $error("capture high byte read inconsistent");
    AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        (flags & ~IRQ_BITS_USED) == RESET_BYTE && (mask & ~IRQ_BITS_USED) == RESET_BYTE)
        else $error("reserved irq bit set");
    AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_flags && io_wdata[BIT_OVERFLOW] && !ev_overflow) |=> !flags[BIT_OVERFLOW])
        else $error("overflow flag not cleared by write one");
    AST_IRQ_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        irq_match_b |-> $past(global_irq_enable && mask[BIT_MATCH_B] && flags[BIT_MATCH_B]))
        else $error("match b request without enable");
    AST_OVF_NORMAL: assert property (@(posedge clock) disable iff (!rst_n)
        (timer_tick && !wr_cnt && seq == SEQ_NORMAL && count == COUNT_MAX)
        |=> flags[BIT_OVERFLOW] && count == COUNT_BOTTOM)
        else $error("overflow not flagged at max");
endmodule : timer16_regs

// *** timer16_cpu_model.sv ***
`timescale 1ns/1ps
// cpu side of the byte-wide i/o port; every access starts just after an edge
module timer16_cpu_model (
    // clock
    input wire logic clock,
    // i/o register port
    output logic [3:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    initial begin
        io_addr = 4'hf;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    // one byte write; released lines flip so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clock);
        #1;
        io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask : wr

    // one byte read; data is taken a full cycle after the strobe, it holds
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clock);
        #1;
        io_rd = 1'b0;
        io_addr = ~a;
        @(posedge clock);
        #1;
        d = io_rdata;
    endtask : rd

    // 16-bit write: high byte into the shared latch first, low byte commits;
    // the strobe stays up across both bytes, so the pair goes back to back
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        @(posedge clock);
        #1;
        io_addr = lo + 4'h1;
        io_wdata = v[15:8];
        io_wr = 1'b1;
        @(posedge clock);
        #1;
        io_addr = lo;
        io_wdata = v[7:0];
        @(posedge clock);
        #1;
        io_wr = 1'b0;
        io_addr = ~lo;
        io_wdata = ~v[7:0];
    endtask : wr16

    // 16-bit read: low byte first latches the high one, strobes back to back
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        @(posedge clock);
        #1;
        io_addr = lo;
        io_rd = 1'b1;
        @(posedge clock);
        #1;
        io_addr = lo + 4'h1;
        v[7:0] = io_rdata;
        @(posedge clock);
        #1;
        io_rd = 1'b0;
        io_addr = ~lo;
        v[15:8] = io_rdata;
    endtask : rd16
endmodule : timer16_cpu_model

// *** sixteen_bit_timer_regs_tb_top.sv ***
`timescale 1ns/1ps
module sixteen_bit_timer_regs_tb_top;
    import timer16_pkg::*;
    logic clock, rst_n, io_wr, io_rd, timer_tick, capture_event, global_irq_enable;
    logic ack_capture, ack_match_a, ack_match_b, ack_overflow;
    logic [3:0] io_addr, waveform_mode_select;
    logic [7:0] io_wdata, io_rdata, rd_val;
    logic [15:0] rd_word;
    logic irq_capture, irq_match_a, irq_match_b, irq_overflow;
    logic match_a, match_b, force_match_a, force_match_b;
    int err_count = 0;
    int num_checks = 0;

    timer16_regs DUT (.clock(clock), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .timer_tick(timer_tick),
        .waveform_mode_select(waveform_mode_select), .capture_event(capture_event),
        .global_irq_enable(global_irq_enable), .ack_capture(ack_capture),
        .ack_match_a(ack_match_a), .ack_match_b(ack_match_b), .ack_overflow(ack_overflow),
        .irq_capture(irq_capture), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
        .irq_overflow(irq_overflow), .match_a(match_a), .match_b(match_b),
        .force_match_a(force_match_a), .force_match_b(force_match_b));
    timer16_cpu_model CPU (.clock(clock), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata));

    ////////////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t byte got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk1

    // read one register and compare the byte
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        CPU.rd(a, rd_val);
        chk8(rd_val, exp);
    endtask : rchk

    // one-cycle pulse on an event input: 0 tick, 1 capture, 2 ack a, 3 ack capture,
    // 4 ack overflow, 5 ack b
    task automatic pulse(input int sel);
        @(posedge clock);
        #1;
        case (sel)
            0: timer_tick = 1'b1;
            1: capture_event = 1'b1;
            2: ack_match_a = 1'b1;
            3: ack_capture = 1'b1;
            4: ack_overflow = 1'b1;
            default: ack_match_b = 1'b1;
        endcase
        @(posedge clock);
        #1;
        {timer_tick, capture_event, ack_match_a, ack_capture, ack_overflow, ack_match_b} = 6'h00;
    endtask : pulse

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        rchk(ADDR_FLAGS, RESET_FLAGS);
        rchk(ADDR_MASK, 8'h00);
        rchk(ADDR_FORCE, 8'h00);
    endtask : t_reset

    // counter pair: low read latches high; the write blocks the next match
    task automatic t_count_match;
        CPU.wr16(ADDR_CMPA_LO, 16'h0005);
        CPU.wr16(ADDR_CMPB_LO, 16'h0007);
        rchk(ADDR_CMPA_HI, 8'h00);
        rchk(ADDR_CMPB_LO, 8'h07);
        CPU.wr16(ADDR_CNT_LO, 16'h0005);
        // tick in the very cycle after the counter write
        timer_tick = 1'b1;
        @(posedge clock);
        #1;
        timer_tick = 1'b0;
        chk1(match_a, 1'b0);
        pulse(0);
        chk1(match_b, 1'b0);
        pulse(0);
        chk1(match_b, 1'b1);
        rchk(ADDR_FLAGS, 8'h04);
        CPU.wr(ADDR_FLAGS, 8'h04);
        rchk(ADDR_FLAGS, 8'h00);
        rchk(ADDR_CNT_LO, 8'h08);
        rchk(ADDR_CNT_HI, 8'h00);
    endtask : t_count_match

    // enabled match a raises its request; the vector ack clears it
    task automatic t_irq_ack;
        CPU.wr(ADDR_MASK, 8'h02);
        global_irq_enable = 1'b1;
        CPU.wr16(ADDR_CMPA_LO, 16'h0008);
        pulse(0);
        chk1(match_a, 1'b1);
        @(posedge clock);
        #1;
        chk1(irq_match_a, 1'b1);
        pulse(2);
        rchk(ADDR_FLAGS, 8'h00);
        chk1(irq_match_a, 1'b0);
    endtask : t_irq_ack

    // strobes act only in non-pwm modes and leave flags and counter alone
    task automatic t_force;
        waveform_mode_select = 4'h4;
        CPU.wr(ADDR_FORCE, 8'h80);
        chk1(force_match_a, 1'b1);
        chk1(force_match_b, 1'b0);
        rchk(ADDR_FLAGS, 8'h00);
        chk1(irq_match_a, 1'b0);
        rchk(ADDR_FORCE, 8'h00);
        rchk(ADDR_CNT_LO, 8'h09);
        CPU.wr(ADDR_FORCE, 8'h40);
        chk1(force_match_b, 1'b1);
        chk1(force_match_a, 1'b0);
        waveform_mode_select = 4'h5;
        CPU.wr(ADDR_FORCE, 8'h00);
        // deliberate misuse: strobes in a pwm mode must be refused
        CPU.wr(ADDR_FORCE, 8'hc0);
        chk1(force_match_a, 1'b0);
        chk1(force_match_b, 1'b0);
        waveform_mode_select = 4'h0;
    endtask : t_force

    // wrap from max sets overflow in normal mode
    task automatic t_overflow;
        CPU.wr16(ADDR_CNT_LO, COUNT_MAX);
        pulse(0);
        rchk(ADDR_FLAGS, 8'h01);
        CPU.wr(ADDR_FLAGS, 8'h01);
        rchk(ADDR_FLAGS, 8'h00);
    endtask : t_overflow

    // capture snapshot, read low then high; mask drops unused bits
    task automatic t_capture_mask;
        CPU.wr16(ADDR_CNT_LO, 16'h1234);
        pulse(1);
        rchk(ADDR_FLAGS, 8'h20);
        CPU.rd16(ADDR_CAP_LO, rd_word);
        chk8(rd_word[7:0], 8'h34);
        chk8(rd_word[15:8], 8'h12);
        CPU.wr(ADDR_MASK, 8'hff);
        rchk(ADDR_MASK, IRQ_BITS_USED);
        chk1(irq_capture, 1'b1);
        pulse(3);
        rchk(ADDR_FLAGS, 8'h00);
        chk1(irq_capture, 1'b0);
    endtask : t_capture_mask

    // capture as top: fast mode flags at top, phase mode overflows at bottom
    task automatic t_top_modes;
        waveform_mode_select = 4'he;
        CPU.wr16(ADDR_CAP_LO, 16'h0003);
        CPU.wr16(ADDR_CMPB_LO, 16'h0001);
        CPU.wr16(ADDR_CNT_LO, 16'h0003);
        pulse(0);
        rchk(ADDR_FLAGS, 8'h21);
        chk1(irq_overflow, 1'b1);
        pulse(4);
        pulse(3);
        pulse(1);
        rchk(ADDR_FLAGS, 8'h00);
        chk1(irq_overflow, 1'b0);
        rchk(ADDR_CAP_LO, 8'h03);
        rchk(ADDR_CNT_LO, 8'h00);
        waveform_mode_select = 4'ha;
        CPU.wr16(ADDR_CNT_LO, 16'h0003);
        repeat (3) pulse(0);
        rchk(ADDR_FLAGS, 8'h24);
        chk1(irq_match_b, 1'b1);
        pulse(0);
        rchk(ADDR_FLAGS, 8'h25);
        CPU.wr(ADDR_FLAGS, 8'h21);
        pulse(5);
        rchk(ADDR_FLAGS, 8'h00);
        chk1(irq_match_b, 1'b0);
        waveform_mode_select = 4'h0;
    endtask : t_top_modes

    ////////////////////////////////////////////////////////////////////////////
    // main sequence after a ten-cycle reset
    initial begin
        rst_n = 1'b0;
        {timer_tick, capture_event, ack_match_a, ack_capture, ack_overflow, ack_match_b} = 6'h00;
        global_irq_enable = 1'b0;
        waveform_mode_select = 4'h0;
        repeat (10) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_count_match();
        t_irq_ack();
        t_force();
        t_overflow();
        t_capture_mask();
        t_top_modes();
        wrap_up();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #40000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : sixteen_bit_timer_regs_tb_top
